// ### shared/lshr_pkg.sv
package lshr_pkg;

  // lead register layout
  localparam int          LEAD_W          = 8;
  localparam int          BIT_DSR_DTR     = 5;
  localparam int          BIT_RLSD_RTS    = 4;
  localparam int          BIT_RL_TM       = 3;
  localparam int          BIT_LL_CTS      = 2;
  localparam int          BIT_DTR_DSR     = 1;
  localparam int          BIT_RTS_RLSD    = 0;
  localparam logic [7:0]  LEAD_USED_MASK  = 8'h3F;
  localparam logic [7:0]  LIVE_RST        = 8'h00;
  localparam logic [7:0]  HIST_RST        = 8'h00;
  localparam logic [7:0]  HIST_EN_RST     = 8'h00;

  // command opcodes; any other value is unrecognized
  localparam int          OP_W            = 4;
  localparam logic [3:0]  OP_CLEAR_ERR    = 4'h1;
  localparam logic [3:0]  OP_CLEAR_PRINT  = 4'h2;
  localparam logic [3:0]  OP_QUERY_ERROR  = 4'h3;
  localparam logic [3:0]  OP_QUERY_LIVE   = 4'h4;
  localparam logic [3:0]  OP_QUERY_HIST   = 4'h5;
  localparam logic [3:0]  OP_SET_HIST_EN  = 4'h6;
  localparam logic [3:0]  OP_QUERY_HIST_EN = 4'h7;
  localparam logic [3:0]  OP_QUERY_PRINT  = 4'h8;

  // error codes held as three bcd digits
  localparam logic [11:0] ERR_NONE        = 12'h000;
  localparam logic [11:0] ERR_UNRECOGNIZED = 12'h107;
  localparam logic [11:0] ERR_PRINT_EMPTY = 12'h219;

  // message text, ascii, first character in the top byte
  localparam logic [87:0] MSG_NONE        = 88'h224E6F204572726F727322;
  localparam int          MSG_NONE_LAST   = 10;
  localparam logic [55:0] MSG_ERR_HEAD    = 56'h224552524F5228;
  localparam logic [15:0] MSG_ERR_TAIL    = 16'h2922;
  localparam int          MSG_ERR_LAST    = 11;
  localparam logic [7:0]  CH_DIGIT0       = 8'h30;

  localparam int          ERR_DEPTH_DEF   = 8;
  localparam int          PRINT_DEPTH_DEF = 16;

  typedef struct packed {
    logic dsr;
    logic dtr;
    logic rlsd;
    logic rts;
    logic rl;
    logic tm;
    logic ll;
    logic cts;
  } lshr_leads_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } lshr_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_STREAM = 2'b10
  } lshr_state_t;

endpackage

// ### src/lshr_lead_sync.sv
`timescale 1ns/1ps
module lshr_lead_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic raw,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // only a value seen on two later stages counts; filters a metastable first stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level = level_q;
endmodule

// ### src/lshr_status_regs.sv
`timescale 1ns/1ps
module lshr_status_regs
  import lshr_pkg::*;
#(
  parameter int ERR_DEPTH   = lshr_pkg::ERR_DEPTH_DEF,
  parameter int PRINT_DEPTH = lshr_pkg::PRINT_DEPTH_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire lshr_pkg::lshr_leads_t leads,
  input  wire logic                 emulate_dte,
  input  wire logic                 cmd_valid,
  input  wire logic [3:0]           cmd_op,
  input  wire logic [7:0]           cmd_arg,
  output logic                      cmd_ready,
  input  wire logic                 prt_valid,
  input  wire logic [7:0]           prt_data,
  output logic                      prt_ready,
  output lshr_pkg::lshr_rsp_t       rsp,
  output logic [7:0]                lead_live,
  output logic                      lead_live_state_summary
);
  import lshr_pkg::*;

  localparam int EW  = $clog2(ERR_DEPTH);
  localparam int ECW = $clog2(ERR_DEPTH + 1);
  localparam int PW  = $clog2(PRINT_DEPTH);
  localparam int PCW = $clog2(PRINT_DEPTH + 1);

  // lead synchronisers
  logic [8:0]  raw_pins;
  logic [8:0]  sync_pins;
  lshr_leads_t s_leads;
  logic        dte_s;

  assign raw_pins = {emulate_dte, leads};
  assign s_leads  = lshr_leads_t'(sync_pins[7:0]);
  assign dte_s    = sync_pins[8];

  for (genvar i = 0; i < 9; i++) begin : g_sync
    lshr_lead_sync u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .raw     (raw_pins[i]),
      .level   (sync_pins[i])
    );
  end

  // live lead map
  logic [7:0] live_d;
  logic [7:0] live_q;
  logic [7:0] rise;

  always_comb begin
    live_d               = 8'h00;
    live_d[BIT_DSR_DTR]  = dte_s ? s_leads.dtr  : s_leads.dsr;
    live_d[BIT_RLSD_RTS] = dte_s ? s_leads.rts  : s_leads.rlsd;
    live_d[BIT_RL_TM]    = dte_s ? s_leads.tm   : s_leads.rl;
    live_d[BIT_LL_CTS]   = dte_s ? s_leads.cts  : s_leads.ll;
    live_d[BIT_DTR_DSR]  = dte_s ? s_leads.dsr  : s_leads.dtr;
    live_d[BIT_RTS_RLSD] = dte_s ? s_leads.rlsd : s_leads.rts;
  end

  // a change of emulation mode may itself show up as a rise
  assign rise = live_d & ~live_q & LEAD_USED_MASK;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      live_q <= LIVE_RST;
    end else begin
      live_q <= live_d;
    end
  end

  // command decode
  lshr_state_t state_q;
  logic        cmd_ready_q;
  logic        accept;
  logic        do_clr_err;
  logic        do_clr_prt;
  logic        do_q_err;
  logic        do_q_live;
  logic        do_q_hist;
  logic        do_set_en;
  logic        do_q_en;
  logic        do_q_prt;
  logic        do_unknown;

  assign accept     = cmd_valid & cmd_ready_q;
  assign do_clr_err = accept && (cmd_op == OP_CLEAR_ERR);
  assign do_clr_prt = accept && (cmd_op == OP_CLEAR_PRINT);
  assign do_q_err   = accept && (cmd_op == OP_QUERY_ERROR);
  assign do_q_live  = accept && (cmd_op == OP_QUERY_LIVE);
  assign do_q_hist  = accept && (cmd_op == OP_QUERY_HIST);
  assign do_set_en  = accept && (cmd_op == OP_SET_HIST_EN);
  assign do_q_en    = accept && (cmd_op == OP_QUERY_HIST_EN);
  assign do_q_prt   = accept && (cmd_op == OP_QUERY_PRINT);
  assign do_unknown = accept && !(do_clr_err || do_clr_prt || do_q_err || do_q_live ||
                                  do_q_hist || do_set_en || do_q_en || do_q_prt);

  // rise history and enable mask
  logic [7:0] hist_q;
  logic [7:0] hist_en_q;
  logic       summary_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_q <= HIST_RST;
    end else if (do_q_hist) begin
      hist_q <= rise;
    end else begin
      hist_q <= hist_q | rise;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_en_q <= HIST_EN_RST;
    end else if (do_set_en) begin
      hist_en_q <= cmd_arg & LEAD_USED_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= |(hist_q & hist_en_q);
    end
  end

  // print buffer
  logic [7:0]     prt_mem [PRINT_DEPTH];
  logic [PW-1:0]  prt_wptr_q;
  logic [PW-1:0]  prt_rptr_q;
  logic [PCW-1:0] prt_cnt_q;
  logic [PCW-1:0] prt_cnt_d;
  logic           prt_ready_q;
  logic           prt_push;
  logic           prt_pop;
  logic           prt_empty;
  logic [PW-1:0]  prt_waddr;

  assign prt_empty = (prt_cnt_q == '0);
  assign prt_push  = prt_valid & prt_ready_q;
  assign prt_pop   = do_q_prt & ~prt_empty;
  // a byte written with the clear survives it
  assign prt_waddr = do_clr_prt ? '0 : prt_wptr_q;

  always_comb begin
    if (do_clr_prt) begin
      prt_cnt_d = prt_push ? PCW'(1) : '0;
    end else begin
      prt_cnt_d = prt_cnt_q + PCW'(prt_push) - PCW'(prt_pop);
    end
  end

  always_ff @(posedge clk) begin
    if (prt_push) begin
      prt_mem[prt_waddr] <= prt_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prt_cnt_q   <= '0;
      prt_ready_q <= 1'b1;
    end else begin
      prt_cnt_q   <= prt_cnt_d;
      prt_ready_q <= (prt_cnt_d != PCW'(PRINT_DEPTH));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prt_wptr_q <= '0;
    end else if (prt_push) begin
      prt_wptr_q <= (prt_waddr == PW'(PRINT_DEPTH - 1)) ? '0 : prt_waddr + 1'b1;
    end else if (do_clr_prt) begin
      prt_wptr_q <= '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prt_rptr_q <= '0;
    end else if (do_clr_prt) begin
      prt_rptr_q <= '0;
    end else if (prt_pop) begin
      prt_rptr_q <= (prt_rptr_q == PW'(PRINT_DEPTH - 1)) ? '0 : prt_rptr_q + 1'b1;
    end
  end

  // error queue; when full the oldest entry is overwritten, newest kept
  logic [11:0]    err_mem [ERR_DEPTH];
  logic [EW-1:0]  err_wptr_q;
  logic [ECW-1:0] err_cnt_q;
  logic           err_push;
  logic [11:0]    err_code_in;
  logic [EW-1:0]  err_newest;

  assign err_push    = do_unknown | (do_q_prt & prt_empty);
  assign err_code_in = do_unknown ? ERR_UNRECOGNIZED : ERR_PRINT_EMPTY;
  assign err_newest  = (err_wptr_q == '0) ? EW'(ERR_DEPTH - 1) : err_wptr_q - 1'b1;

  always_ff @(posedge clk) begin
    if (err_push) begin
      err_mem[err_wptr_q] <= err_code_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_wptr_q <= '0;
      err_cnt_q  <= '0;
    end else if (err_push) begin
      err_wptr_q <= (err_wptr_q == EW'(ERR_DEPTH - 1)) ? '0 : err_wptr_q + 1'b1;
      if (err_cnt_q != ECW'(ERR_DEPTH)) begin
        err_cnt_q <= err_cnt_q + 1'b1;
      end
    end else if (do_clr_err) begin
      err_cnt_q <= '0;
    end
  end

  // message character generator
  function automatic logic [8:0] msg_char(input logic [11:0] code, input logic [3:0] idx);
    logic [7:0] ch;
    logic       last;
    ch   = 8'h00;
    last = 1'b0;
    if (code == ERR_NONE) begin
      ch   = MSG_NONE[8 * (MSG_NONE_LAST - int'(idx)) +: 8];
      last = (int'(idx) == MSG_NONE_LAST);
    end else begin
      case (idx)
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: ch = MSG_ERR_HEAD[8 * (6 - int'(idx)) +: 8];
        4'h7:    ch = CH_DIGIT0 + {4'h0, code[11:8]};
        4'h8:    ch = CH_DIGIT0 + {4'h0, code[7:4]};
        4'h9:    ch = CH_DIGIT0 + {4'h0, code[3:0]};
        4'hA:    ch = MSG_ERR_TAIL[15:8];
        default: ch = MSG_ERR_TAIL[7:0];
      endcase
      last = (int'(idx) == MSG_ERR_LAST);
    end
    return {last, ch};
  endfunction

  // answer sequencer
  logic [11:0] msg_code_q;
  logic [3:0]  msg_idx_q;
  lshr_rsp_t   rsp_q;
  logic [8:0]  cur_char;

  assign cur_char = msg_char(msg_code_q, msg_idx_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= ST_IDLE;
      cmd_ready_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (do_q_err || err_push) begin
            state_q     <= ST_STREAM;
            cmd_ready_q <= 1'b0;
          end
        end
        ST_STREAM: begin
          if (cur_char[8]) begin
            state_q     <= ST_IDLE;
            cmd_ready_q <= 1'b1;
          end
        end
        default: begin
          state_q     <= ST_IDLE;
          cmd_ready_q <= 1'b1;
        end
      endcase
    end
  end

  // index restarts in idle, so a string always opens with its quote
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msg_code_q <= ERR_NONE;
      msg_idx_q  <= 4'h0;
    end else if (state_q == ST_STREAM) begin
      msg_idx_q <= msg_idx_q + 1'b1;
    end else begin
      msg_idx_q <= 4'h0;
      if (do_q_err) begin
        msg_code_q <= (err_cnt_q == '0) ? ERR_NONE : err_mem[err_newest];
      end else if (err_push) begin
        // the failed command is answered with its own message
        msg_code_q <= err_code_in;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_q <= '0;
    end else if (state_q == ST_STREAM) begin
      rsp_q <= '{valid: 1'b1, last: cur_char[8], data: cur_char[7:0]};
    end else if (do_q_live) begin
      rsp_q <= '{valid: 1'b1, last: 1'b1, data: live_q};
    end else if (do_q_hist) begin
      rsp_q <= '{valid: 1'b1, last: 1'b1, data: hist_q};
    end else if (do_q_en) begin
      rsp_q <= '{valid: 1'b1, last: 1'b1, data: hist_en_q};
    end else if (prt_pop) begin
      rsp_q <= '{valid: 1'b1, last: 1'b1, data: prt_mem[prt_rptr_q]};
    end else begin
      rsp_q.valid <= 1'b0;
      rsp_q.last  <= 1'b0;
    end
  end

  assign cmd_ready    = cmd_ready_q;
  assign prt_ready    = prt_ready_q;
  assign rsp          = rsp_q;
  assign lead_live    = live_q;
  assign lead_live_state_summary = summary_q;
endmodule

// ### verification/lshr_status_regs_properties.sv
`timescale 1ns/1ps
module lshr_status_regs_chk
  import lshr_pkg::*;
#(
  parameter int ERR_DEPTH   = 8,
  parameter int PRINT_DEPTH = 16
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire lshr_pkg::lshr_leads_t leads,
  input wire logic                  emulate_dte,
  input wire logic                  cmd_valid,
  input wire logic [3:0]            cmd_op,
  input wire logic                  cmd_ready,
  input wire lshr_pkg::lshr_rsp_t   rsp,
  input wire logic [7:0]            lead_live
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [8:0] prev_q;
  logic [2:0] st_q;
  logic [7:0] map;
  logic       tk;
  assign tk = cmd_valid && cmd_ready;
  assign map = emulate_dte ? {2'b00, leads.dtr, leads.rts, leads.tm, leads.cts, leads.dsr, leads.rlsd}
                           : {2'b00, leads.dsr, leads.rlsd, leads.rl, leads.ll, leads.dtr, leads.rts};
  // pins pass a sync chain, so judge the live value only after 7 quiet edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 9'h000;
      st_q <= 3'h0;
    end else begin
      prev_q <= {leads, emulate_dte};
      if ({leads, emulate_dte} != prev_q) begin
        st_q <= 3'h0;
      end else if (st_q != 3'h7) begin
        st_q <= st_q + 3'h1;
      end
    end
  end
  property p_unused;
    lead_live[7:6] == 2'b00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused live bits set");
  property p_live_map;
    st_q == 3'h7 && {leads, emulate_dte} == prev_q |-> lead_live == map;
  endproperty
  a_live_map: assert property (p_live_map) else $error("live value wrong");
  property p_live_rd;
    tk && cmd_op == OP_QUERY_LIVE |=> rsp.valid && rsp.last && rsp.data == $past(lead_live);
  endproperty
  a_live_rd: assert property (p_live_rd) else $error("live answer wrong");
  property p_hist_rd;
    tk && cmd_op == OP_QUERY_HIST |=> rsp.valid && rsp.last && rsp.data[7:6] == 2'b00;
  endproperty
  a_hist_rd: assert property (p_hist_rd) else $error("history answer wrong");
  property p_err_open;
    tk && cmd_op == OP_QUERY_ERROR |=> !rsp.valid ##1 rsp.valid && rsp.data == 8'h22;
  endproperty
  a_err_open: assert property (p_err_open) else $error("error string start wrong");
  property p_err_close;
    tk && cmd_op == OP_QUERY_ERROR |-> ##[12:13] rsp.valid && rsp.last && rsp.data == 8'h22;
  endproperty
  a_err_close: assert property (p_err_close) else $error("error string end wrong");
  property p_unrec;
    tk && (cmd_op == 4'h0 || cmd_op > 4'h8) |-> ##9 rsp.data == 8'h31 ##1 rsp.data == 8'h30 ##1 rsp.data == 8'h37;
  endproperty
  a_unrec: assert property (p_unrec) else $error("unknown command code wrong");
  property p_clear;
    tk && (cmd_op == OP_CLEAR_ERR || cmd_op == OP_CLEAR_PRINT) |=> !rsp.valid;
  endproperty
  a_clear: assert property (p_clear) else $error("clear gave an answer");
endmodule
bind lshr_status_regs lshr_status_regs_chk #(.ERR_DEPTH(ERR_DEPTH), .PRINT_DEPTH(PRINT_DEPTH)) chk_u (
  .clk, .reset_n, .leads, .emulate_dte, .cmd_valid, .cmd_op, .cmd_ready, .rsp, .lead_live);

// ### verification/lshr_host_model.sv
`timescale 1ns/1ps
module lshr_host_model
  import lshr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                cmd_ready,
  input  wire lshr_pkg::lshr_rsp_t rsp,
  output logic                     cmd_valid,
  output logic [3:0]               cmd_op,
  output logic [7:0]               cmd_arg
);
  logic [7:0] rx[$];
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_arg = 8'h00;
  end
  always @(posedge clk) begin
    if (rsp.valid === 1'b1) rx.push_back(rsp.data);
  end
  // 15 edges cover the longest answer string
  task automatic send(input logic [3:0] op, input logic [7:0] arg);
    rx.delete();
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_arg = arg;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #1;
    cmd_valid = 1'b0;
    repeat (15) @(posedge clk);
  endtask
endmodule

// ### verification/tb_lshr_status_regs.sv
`timescale 1ns/1ps
module tb_lshr_status_regs;
  import lshr_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  lshr_leads_t leads = '0;
  logic        emulate_dte = 1'b0;
  logic        prt_valid = 1'b0;
  logic [7:0]  prt_data = 8'h00;
  logic        cmd_valid, cmd_ready, prt_ready, lead_live_state_summary;
  logic [3:0]  cmd_op;
  logic [7:0]  cmd_arg, lead_live, old, e, b;
  logic [8:0]  v;
  lshr_rsp_t   rsp;
  int          failures = 0;
  int          n_tests = 0;
  int          seed = 78;
  always #25 clk = ~clk;
  lshr_status_regs dut_u (.clk, .reset_n, .leads, .emulate_dte, .cmd_valid, .cmd_op, .cmd_arg,
    .cmd_ready, .prt_valid, .prt_data, .prt_ready, .rsp, .lead_live, .lead_live_state_summary);
  lshr_host_model host_u (.clk, .cmd_ready, .rsp, .cmd_valid, .cmd_op, .cmd_arg);
  function automatic logic [7:0] live_of(lshr_leads_t l, logic d);
    return d ? {2'b00, l.dtr, l.rts, l.tm, l.cts, l.dsr, l.rlsd} : {2'b00, l.dsr, l.rlsd, l.rl, l.ll, l.dtr, l.rts};
  endfunction
  task chk(input string nm, input logic [7:0] s, input logic [7:0] x);
    n_tests++;
    if (s !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task settle(input logic [8:0] w);
    @(posedge clk);
    #1;
    {leads, emulate_dte} = w;
    repeat (7) @(posedge clk);
  endtask
  task wr(input logic [7:0] d);
    @(posedge clk);
    #1;
    prt_valid = 1'b1;
    prt_data = d;
    do @(posedge clk); while (prt_ready !== 1'b1);
    #1;
    prt_valid = 1'b0;
  endtask
  task str_chk(input logic [11:0] c);
    chk("first", host_u.rx[0], 8'h22);
    chk("final", host_u.rx[$], 8'h22);
    if (c === 12'h000) begin
      chk("len", 8'(host_u.rx.size()), 8'h0B);
      chk("text", host_u.rx[1], 8'h4E);
    end else begin
      chk("len", 8'(host_u.rx.size()), 8'h0C);
      for (int k = 0; k < 3; k++) chk("digit", host_u.rx[7+k], 8'h30 + 8'(c[11-4*k -: 4]));
    end
  endtask
  initial begin
    #(3000 * 50);
    failures++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      v = (i < 2) ? {8'hFF, i[0]} : 9'($random(seed));
      settle(v);
      host_u.send(OP_QUERY_LIVE, 8'h00);
      chk("live", host_u.rx[0], live_of(leads, emulate_dte));
      chk("live_port", lead_live, live_of(leads, emulate_dte));
    end
    $display("test live done");
    host_u.send(OP_SET_HIST_EN, 8'hFF);
    host_u.send(OP_QUERY_HIST_EN, 8'h00);
    chk("mask", host_u.rx[0], 8'h3F);
    host_u.send(OP_QUERY_HIST, 8'h00);
    for (int i = 0; i < 8; i++) begin
      b = (i < 2) ? 8'hFF : 8'($random(seed));
      host_u.send(OP_SET_HIST_EN, b);
      old = live_of(leads, emulate_dte);
      v = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FE : 9'($random(seed));
      settle(v);
      e = live_of(leads, emulate_dte) & ~old;
      chk("summary", {7'h00, lead_live_state_summary}, {7'h00, |(e & b)});
      host_u.send(OP_QUERY_HIST, 8'h00);
      chk("hist", host_u.rx[0], e);
      host_u.send(OP_QUERY_HIST, 8'h00);
      chk("hist_clr", host_u.rx[0], 8'h00);
    end
    settle(9'h000);
    host_u.send(OP_QUERY_HIST, 8'h00);
    @(posedge clk);
    #1;
    {leads, emulate_dte} = 9'h100;
    // the rise reaches history at the fifth edge, where this read is taken
    repeat (3) @(posedge clk);
    host_u.send(OP_QUERY_HIST, 8'h00);
    chk("hist_race", host_u.rx[0], 8'h00);
    host_u.send(OP_QUERY_HIST, 8'h00);
    chk("hist_kept", host_u.rx[0], 8'h20);
    $display("test history done");
    b = 8'($random(seed));
    wr(b);
    wr(~b);
    host_u.send(OP_QUERY_PRINT, 8'h00);
    chk("print", host_u.rx[0], b);
    host_u.send(OP_CLEAR_PRINT, 8'h00);
    host_u.send(OP_QUERY_PRINT, 8'h00);
    str_chk(12'h219);
    host_u.send(4'hB, 8'h00);
    str_chk(12'h107);
    host_u.send(OP_QUERY_ERROR, 8'h00);
    str_chk(12'h107);
    host_u.send(OP_CLEAR_ERR, 8'h00);
    host_u.send(OP_QUERY_ERROR, 8'h00);
    str_chk(12'h000);
    for (int i = 0; i < 16; i++) wr(8'(i * 37));
    chk("full", {7'h00, prt_ready}, 8'h00);
    host_u.send(OP_CLEAR_PRINT, 8'h00);
    chk("cleared", {7'h00, prt_ready}, 8'h01);
    host_u.send(OP_QUERY_PRINT, 8'h00);
    str_chk(12'h219);
    $display("test queues done");
    stop_test();
  end
endmodule
